// File: design/adbk_top.sv
// Purpose: address break comparator watching the CPU internal buses
// Assumes: CPU monitor inputs are on MCLK; one valid pulse per bus cycle
// Notes: APB slave answers in the second access cycle
//
// Design decisions made here: the APB slave port and the register addresses.
`timescale 1ns/100ps
module adbk_top
  import adbk_pkg::*;
(
  // clock and reset
  input wire logic MCLK,
  input wire logic RST_N,
  // apb slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // cpu bus monitor
  input wire logic CPU_CYC_VALID,
  input wire logic CPU_CYC_FETCH,
  input wire logic CPU_CYC_WRITE,
  input wire logic CPU_CYC_WORD,
  input wire logic [1:0] CPU_SPACE,
  input wire logic [15:0] CPU_ADDR,
  input wire logic [15:0] CPU_DATA,
  // cpu sequencing
  input wire logic CPU_INSN_END,
  input wire logic CPU_RTE_DONE,
  input wire logic CPU_BREAK_ACK,
  // requests to the cpu
  output logic BREAK_IRQ,
  output logic EXC_START,
  output logic IRQ_BLOCK,
  // system interrupt
  output logic EVT_IRQ
);

  // ==========================================================
  // apb handshake
  logic pready_r;
  logic pslverr_r;
  logic [31:0] prdata_r;
  logic [31:0] rdata;
  logic hit;
  logic access;
  logic done;
  logic wr_done;
  logic rd_done;

  assign access = PSEL & PENABLE & ~pready_r;
  assign done = PSEL & PENABLE & pready_r;
  assign wr_done = done & PWRITE;
  assign rd_done = done & ~PWRITE;

  // ==========================================================
  // register state
  logic [7:0] ctrl_r;
  logic flag_r;
  logic flag_nxt;
  logic ie_r;
  logic ie_nxt;
  logic arm_r;
  logic [15:0] baddr_r;
  logic [15:0] bdata_r;
  logic [EVT_W-1:0] evt_r;
  logic [EVT_W-1:0] evt_nxt;
  logic [EVT_W-1:0] emask_r;
  logic [EVT_W-1:0] emask_nxt;

  always_comb begin
    hit = 1'b1;
    rdata = 32'h0;
    case (PADDR)
      ADR_CTRL: rdata[7:0] = ctrl_r;
      ADR_STAT: rdata[7:0] = {flag_r, ie_r, STAT_RSVD};
      ADR_BADDR: rdata[15:0] = baddr_r;
      ADR_BDATA: rdata[15:0] = bdata_r;
      ADR_EVT: rdata[EVT_W-1:0] = evt_r;
      ADR_EMASK: rdata[EVT_W-1:0] = emask_r;
      default: hit = 1'b0;
    endcase
  end

  // read data is frozen at the first access cycle so it cannot slip under the master
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0;
    end else begin
      pready_r <= access;
      pslverr_r <= access & ~hit;
      if (access) begin
        prdata_r <= PWRITE ? 32'h0 : rdata;
      end
    end
  end

  logic wr_ctrl;
  logic wr_stat;
  logic wr_baddr;
  logic wr_bdata;
  logic wr_evt;
  logic wr_emask;

  assign wr_ctrl = wr_done & (PADDR == ADR_CTRL);
  assign wr_stat = wr_done & (PADDR == ADR_STAT);
  assign wr_baddr = wr_done & (PADDR == ADR_BADDR);
  assign wr_bdata = wr_done & (PADDR == ADR_BDATA);
  assign wr_evt = wr_done & (PADDR == ADR_EVT);
  assign wr_emask = wr_done & (PADDR == ADR_EMASK);

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      ctrl_r <= CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl_r <= PWDATA[7:0];
    end
  end

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      baddr_r <= BADDR_RST;
      bdata_r <= BDATA_RST;
    end else begin
      if (wr_baddr) begin
        baddr_r <= PWDATA[15:0];
      end
      if (wr_bdata) begin
        bdata_r <= PWDATA[15:0];
      end
    end
  end

  // ==========================================================
  // cycle candidate, with 8-bit i/o word split
  adbk_state_t state_r;
  logic [15:0] lat_addr_r;
  logic [7:0] lat_lo_r;
  logic lat_wr_r;
  logic split_go;
  logic c_valid;
  logic c_fetch;
  logic c_write;
  logic c_word;
  logic [15:0] c_addr;
  logic [15:0] c_data;

  // a word to 8-bit i/o is two byte accesses: even byte now, odd byte next cycle
  assign split_go = (state_r == ADBK_IDLE) & CPU_CYC_VALID & CPU_CYC_WORD & ~CPU_CYC_FETCH &
                    (CPU_SPACE == SPACE_IO8);

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      state_r <= ADBK_IDLE;
      lat_addr_r <= 16'h0000;
      lat_lo_r <= 8'h00;
      lat_wr_r <= 1'b0;
    end else begin
      case (state_r)
        ADBK_IDLE: begin
          if (split_go) begin
            state_r <= ADBK_SECOND;
            lat_addr_r <= CPU_ADDR | ODD_BIT;
            lat_lo_r <= CPU_DATA[7:0];
            lat_wr_r <= CPU_CYC_WRITE;
          end
        end
        ADBK_SECOND: state_r <= ADBK_IDLE;
        default: state_r <= ADBK_IDLE;
      endcase
    end
  end

  // a bus cycle that lands on the second half is not looked at; the cpu bus is busy then
  always_comb begin
    c_valid = CPU_CYC_VALID;
    c_fetch = CPU_CYC_FETCH;
    c_write = CPU_CYC_WRITE;
    c_word = CPU_CYC_WORD & (CPU_SPACE != SPACE_IO8);
    c_addr = CPU_ADDR;
    c_data = CPU_DATA;
    if (state_r == ADBK_SECOND) begin
      c_valid = 1'b1;
      c_fetch = 1'b0;
      c_write = lat_wr_r; // direction qualifies only the valid cycle
      c_word = 1'b0;
      c_addr = lat_addr_r;
      c_data = {lat_lo_r, 8'h00}; // odd byte travels on the upper lane
    end
  end

  // ==========================================================
  // comparators
  logic type_ok;
  logic addr_ok;
  logic data_ok;
  logic upper_act;
  logic lower_act;
  logic eq_hi;
  logic eq_lo;
  logic [15:0] amask;
  logic match;

  always_comb begin
    case (ctrl_r[CSEL_HI:CSEL_LO])
      CSEL_FETCH: type_ok = c_fetch;
      CSEL_READ: type_ok = ~c_fetch & ~c_write;
      CSEL_WRITE: type_ok = ~c_fetch & c_write;
      CSEL_RW: type_ok = ~c_fetch;
      default: type_ok = 1'b0;
    endcase
  end

  // reserved compare codes fall back to the full address
  always_comb begin
    case (ctrl_r[ACMP_HI:ACMP_LO])
      ACMP_16: amask = AMASK_16;
      ACMP_12: amask = AMASK_12;
      ACMP_8: amask = AMASK_8;
      ACMP_4: amask = AMASK_4;
      default: amask = AMASK_16;
    endcase
  end

  assign addr_ok = ((c_addr ^ baddr_r) & amask) == 16'h0000;

  // odd word in rom/ram/io16 uses the low lane only; even word in rom/ram/io16 uses both lanes; everything else the upper lane
  assign lower_act = c_word;
  assign upper_act = ~(c_word & c_addr[0]);
  assign eq_hi = c_data[15:8] == bdata_r[15:8];
  assign eq_lo = c_data[7:0] == bdata_r[7:0];

  always_comb begin
    case (ctrl_r[DCMP_HI:DCMP_LO])
      DCMP_NONE: data_ok = 1'b1;
      DCMP_LOW: data_ok = lower_act & eq_lo;
      DCMP_HIGH: data_ok = upper_act & eq_hi;
      DCMP_ALL: data_ok = lower_act & upper_act & eq_lo & eq_hi;
      default: data_ok = 1'b0;
    endcase
  end

  // all three conditions are taken from one candidate cycle
  assign match = c_valid & type_ok & addr_ok & data_ok;

  // ==========================================================
  // break flag and enable
  logic flag_clr;

  assign flag_clr = wr_stat & ~PWDATA[STAT_FLAG_BIT] & arm_r;

  always_comb begin
    flag_nxt = flag_r;
    if (match) begin
      flag_nxt = 1'b1;
    end else if (flag_clr) begin
      flag_nxt = 1'b0;
    end
    ie_nxt = wr_stat ? PWDATA[STAT_IE_BIT] : ie_r;
  end

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      flag_r <= 1'b0;
      ie_r <= 1'b0;
    end else begin
      flag_r <= flag_nxt;
      ie_r <= ie_nxt;
    end
  end

  // the arm is the read of a one; a clear write consumes it
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      arm_r <= 1'b0;
    end else if (rd_done & (PADDR == ADR_STAT) & prdata_r[STAT_FLAG_BIT]) begin
      arm_r <= 1'b1;
    end else if (wr_stat & ~PWDATA[STAT_FLAG_BIT]) begin
      arm_r <= 1'b0;
    end
  end

  // ==========================================================
  // requests to the cpu
  logic break_irq_r;
  logic pend_r;
  logic exc_start_r;
  logic exc_start_nxt;
  logic block_r;
  logic ack_ok;

  // built from next values so the output tracks flag and enable cycle for cycle;
  // no cpu mask input exists here, so the cpu mask can never hide it
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      break_irq_r <= 1'b0;
    end else begin
      break_irq_r <= flag_nxt & ie_nxt;
    end
  end

  assign ack_ok = CPU_BREAK_ACK & break_irq_r;
  assign exc_start_nxt = (pend_r | ack_ok) & CPU_INSN_END;

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      pend_r <= 1'b0;
      exc_start_r <= 1'b0;
    end else begin
      exc_start_r <= exc_start_nxt;
      if (CPU_INSN_END) begin
        pend_r <= 1'b0;
      end else if (ack_ok) begin
        pend_r <= 1'b1;
      end
    end
  end

  // the return itself may end in the same cycle; only a later instruction lifts the block
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      block_r <= 1'b0;
    end else if (CPU_RTE_DONE & ~ctrl_r[CTRL_UNMASK_BIT]) begin
      block_r <= 1'b1;
    end else if (CPU_INSN_END) begin
      block_r <= 1'b0;
    end
  end

  // ==========================================================
  // system event status, write one to clear, set wins
  logic evt_irq_r;
  logic [EVT_W-1:0] evt_set;

  always_comb begin
    evt_set = '0;
    evt_set[EVT_MATCH] = match;
    evt_set[EVT_EXC] = exc_start_nxt;
    evt_nxt = evt_r;
    if (wr_evt) begin
      evt_nxt = evt_r & ~PWDATA[EVT_W-1:0];
    end
    evt_nxt = evt_nxt | evt_set;
    emask_nxt = wr_emask ? PWDATA[EVT_W-1:0] : emask_r;
  end

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      evt_r <= '0;
      emask_r <= '0;
      evt_irq_r <= 1'b0;
    end else begin
      evt_r <= evt_nxt;
      emask_r <= emask_nxt;
      evt_irq_r <= |(evt_nxt & emask_nxt);
    end
  end

  // ==========================================================
  // outputs
  assign PRDATA = prdata_r;
  assign PREADY = pready_r;
  assign PSLVERR = pslverr_r;
  assign BREAK_IRQ = break_irq_r;
  assign EXC_START = exc_start_r;
  assign IRQ_BLOCK = block_r;
  assign EVT_IRQ = evt_irq_r;

endmodule

// File: pkg/adbk_pkg.sv
// Purpose: constants and types of the address break comparator
// Assumes: 32-bit APB data, one aligned word per register
// Notes: register offsets are byte addresses on the APB
//
// Contract
// - break request never gated by the CPU global interrupt mask
// - control bit 7 resets 1; when 0 block interrupts after return till one instruction
// - cycle select 00 fetch, 01 read, 10 write, 11 read or write; reset 00
// - address compare 000 all, 001 top 12, 010 top 8, 011 top 4 bits
// - data compare 00 off, 01 low byte, 10 high byte, 11 all 16 bits
// - lane: word odd in rom/ram/io16 uses low lane, all else upper
// - word access to 8-bit i/o is compared as two byte accesses
// - status bit 7 flag sets when type, address and data all match; reset 0
// - flag clears only by writing 0 after reading it as 1
// - status bit 6 is break interrupt enable, reset 0
// - status bits 5 to 0 always read as 1
// - break address is 16 bits read/write, reset all ones
// - break data high byte against upper bus byte, low against lower
// - break request high exactly while flag and enable are both 1
// - exception start only once the current instruction has completed
package adbk_pkg;
  // ==========================================================
  // register map
  localparam logic [7:0] ADR_CTRL = 8'h00;
  localparam logic [7:0] ADR_STAT = 8'h04;
  localparam logic [7:0] ADR_BADDR = 8'h08;
  localparam logic [7:0] ADR_BDATA = 8'h0c;
  localparam logic [7:0] ADR_EVT = 8'h10;
  localparam logic [7:0] ADR_EMASK = 8'h14;

  // ==========================================================
  // fields
  localparam int CTRL_UNMASK_BIT = 7;
  localparam int CSEL_HI = 6;
  localparam int CSEL_LO = 5;
  localparam int ACMP_HI = 4;
  localparam int ACMP_LO = 2;
  localparam int DCMP_HI = 1;
  localparam int DCMP_LO = 0;
  localparam int STAT_FLAG_BIT = 7;
  localparam int STAT_IE_BIT = 6;
  localparam int EVT_MATCH = 0;
  localparam int EVT_EXC = 1;
  localparam int EVT_W = 2;

  // ==========================================================
  // reset values
  localparam logic [7:0] CTRL_RST = 8'h80;
  localparam logic [5:0] STAT_RSVD = 6'h3f;
  localparam logic [15:0] BADDR_RST = 16'hffff;
  localparam logic [15:0] BDATA_RST = 16'h0000;

  // ==========================================================
  // encodings
  localparam logic [1:0] CSEL_FETCH = 2'h0;
  localparam logic [1:0] CSEL_READ = 2'h1;
  localparam logic [1:0] CSEL_WRITE = 2'h2;
  localparam logic [1:0] CSEL_RW = 2'h3;
  localparam logic [2:0] ACMP_16 = 3'h0;
  localparam logic [2:0] ACMP_12 = 3'h1;
  localparam logic [2:0] ACMP_8 = 3'h2;
  localparam logic [2:0] ACMP_4 = 3'h3;
  localparam logic [15:0] AMASK_16 = 16'hffff;
  localparam logic [15:0] AMASK_12 = 16'hfff0;
  localparam logic [15:0] AMASK_8 = 16'hff00;
  localparam logic [15:0] AMASK_4 = 16'hf000;
  localparam logic [1:0] DCMP_NONE = 2'h0;
  localparam logic [1:0] DCMP_LOW = 2'h1;
  localparam logic [1:0] DCMP_HIGH = 2'h2;
  localparam logic [1:0] DCMP_ALL = 2'h3;
  localparam logic [1:0] SPACE_ROM = 2'h0;
  localparam logic [1:0] SPACE_RAM = 2'h1;
  localparam logic [1:0] SPACE_IO8 = 2'h2;
  localparam logic [1:0] SPACE_IO16 = 2'h3;
  localparam logic [15:0] ODD_BIT = 16'h0001;

  typedef enum logic {ADBK_IDLE, ADBK_SECOND} adbk_state_t;
endpackage

// File: verification/adbk_cpu.sv
// Purpose: behavioural cpu core that drives the monitored buses
// Assumes: one bus cycle per call, launched just after a rising edge
// Notes: released data shows its inverse so a stale value never matches
`timescale 1ns/100ps
module adbk_cpu (
  // clock
  input wire logic clk,
  // monitored bus
  output logic valid,
  output logic fetch,
  output logic write,
  output logic word,
  output logic [1:0] space,
  output logic [15:0] addr,
  output logic [15:0] data,
  // sequencing
  output logic insn_end,
  output logic rte_done,
  output logic break_ack
);
  initial begin
    {valid, fetch, write, word, space, addr, data} = '0;
    {insn_end, rte_done, break_ack} = '0;
  end
  // ==========================================================
  // bus cycle; a fetch carries the first byte address of the insn
  task automatic cyc(input logic f, w, wd, input logic [1:0] sp, input logic [15:0] a, dt);
    @(posedge clk);
    valid <= 1'b1;
    fetch <= f;
    write <= w;
    word <= wd;
    space <= sp;
    addr <= a;
    data <= dt;
    @(posedge clk);
    valid <= 1'b0;
    fetch <= ~f;
    write <= ~w;
    word <= ~wd;
    space <= ~sp;
    addr <= ~a;
    data <= ~dt;
  endtask
  // ==========================================================
  // one-cycle sequencing pulses
  task automatic seq(input logic ack, fin, return_from_exception);
    @(posedge clk);
    break_ack <= ack;
    insn_end <= fin;
    rte_done <= return_from_exception;
    @(posedge clk);
    {break_ack, insn_end, rte_done} <= 3'h0;
  endtask
endmodule

// File: verification/adbk_chk_sva.sv
// Purpose: port-level checks of the address break comparator
// Assumes: one MCLK domain, RST_N asynchronous active low
// Notes: the 8-bit i/o split can set the flag two cycles after valid
`timescale 1ns/100ps
module adbk_chk
  import adbk_pkg::*;
(
  // clock and reset
  input wire logic MCLK,
  input wire logic RST_N,
  // apb
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic PREADY,
  input wire logic PSLVERR,
  // cpu side
  input wire logic CPU_CYC_VALID,
  input wire logic CPU_INSN_END,
  input wire logic CPU_RTE_DONE,
  input wire logic BREAK_IRQ,
  input wire logic EXC_START,
  input wire logic IRQ_BLOCK
);
  default clocking @(posedge MCLK); endclocking
  default disable iff (!RST_N);
  wire logic st_wr = PSEL && PENABLE && PREADY && PWRITE && PADDR == ADR_STAT;
  // ==========================================================
  // apb
  chk_ready_wait: assert property (PSEL && PENABLE && !PREADY |=> PREADY)
    else $error("no ready in second access cycle");
  chk_ready_pulse: assert property (PREADY |=> !PREADY)
    else $error("ready longer than one cycle");
  chk_err_ready: assert property (PSLVERR |-> PREADY)
    else $error("error without ready");
  // ==========================================================
  // break request
  chk_flag_hold: assert property (BREAK_IRQ && !st_wr |=> BREAK_IRQ)
    else $error("break request dropped without status write");
  chk_flag_cause: assert property ($rose(BREAK_IRQ) |->
      $past(CPU_CYC_VALID) || $past(CPU_CYC_VALID, 2) || $past(st_wr))
    else $error("break request rose without cause");
  chk_irq_clear: assert property ($fell(BREAK_IRQ) |-> $past(st_wr))
    else $error("break request fell without status write");
  // ==========================================================
  // exception and return blocking
  chk_exc_after: assert property (EXC_START |-> $past(CPU_INSN_END))
    else $error("exception start before insn end");
  chk_exc_pulse: assert property (EXC_START |=> !EXC_START)
    else $error("exception start longer than one cycle");
  chk_block_set: assert property ($rose(IRQ_BLOCK) |-> $past(CPU_RTE_DONE))
    else $error("block rose without return");
  chk_block_end: assert property ($fell(IRQ_BLOCK) |-> $past(CPU_INSN_END))
    else $error("block fell without insn end");
endmodule

bind adbk_top adbk_chk u_chk (.MCLK, .RST_N, .PSEL, .PENABLE, .PWRITE, .PADDR, .PREADY,
  .PSLVERR, .CPU_CYC_VALID, .CPU_INSN_END, .CPU_RTE_DONE, .BREAK_IRQ, .EXC_START,
  .IRQ_BLOCK);

// File: verification/adbk_top_tb.sv
// Purpose: self-checking bench for the address break comparator
// Assumes: cpu model drives the monitor bus, bench is the apb master
// Notes: outputs are sampled on the falling edge after they update
`timescale 1ns/100ps
module adbk_top_tb
  import adbk_pkg::*;
;
  logic MCLK, RST_N, PSEL, PENABLE, PWRITE;
  logic [7:0] PADDR;
  logic [31:0] PWDATA, PRDATA;
  logic PREADY, PSLVERR, CPU_CYC_VALID, CPU_CYC_FETCH, CPU_CYC_WRITE, CPU_CYC_WORD;
  logic [1:0] CPU_SPACE, cs;
  logic [15:0] CPU_ADDR, CPU_DATA, am;
  logic CPU_INSN_END, CPU_RTE_DONE, CPU_BREAK_ACK, BREAK_IRQ, EXC_START, IRQ_BLOCK, EVT_IRQ;
  logic [31:0] d;
  logic e, exc_seen;
  int n_fail = 0;
  int compares = 0;

  adbk_top dut (.MCLK, .RST_N, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA, .PREADY,
    .PSLVERR, .CPU_CYC_VALID, .CPU_CYC_FETCH, .CPU_CYC_WRITE, .CPU_CYC_WORD, .CPU_SPACE,
    .CPU_ADDR, .CPU_DATA, .CPU_INSN_END, .CPU_RTE_DONE, .CPU_BREAK_ACK, .BREAK_IRQ,
    .EXC_START, .IRQ_BLOCK, .EVT_IRQ);
  adbk_cpu cpu (.clk(MCLK), .valid(CPU_CYC_VALID), .fetch(CPU_CYC_FETCH),
    .write(CPU_CYC_WRITE), .word(CPU_CYC_WORD), .space(CPU_SPACE), .addr(CPU_ADDR),
    .data(CPU_DATA), .insn_end(CPU_INSN_END), .rte_done(CPU_RTE_DONE),
    .break_ack(CPU_BREAK_ACK));

  initial begin
    MCLK = 1'b0;
    forever #20 MCLK = ~MCLK;
  end
  // the exception pulse lasts one cycle, so it is latched for later comparison
  always @(posedge MCLK) begin
    if (EXC_START === 1'b1) exc_seen <= 1'b1;
  end
  // ==========================================================
  // helpers
  task automatic conclude();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic er);
    int n;
    n = 0;
    @(posedge MCLK);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= wd;
    @(posedge MCLK);
    PENABLE <= 1'b1;
    do begin
      @(posedge MCLK);
      n++;
    end while (PREADY !== 1'b1 && n < 16);
    rd = PRDATA;
    er = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    if (PREADY !== 1'b1) begin
      n_fail++;
      $display("[ERR] %0t apb timeout", $time);
      conclude();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    apb(1'b1, a, v, d, e);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] v);
    apb(1'b0, a, 32'h0, d, e);
    chk(d, v);
  endtask
  task automatic settle();
    @(posedge MCLK);
    @(negedge MCLK);
  endtask
  // one cpu cycle, then the request is compared and a raised flag cleared
  task automatic bus(input logic f, w, wd, input logic [1:0] sp,
                     input logic [15:0] a, dt, input logic x);
    cpu.cyc(f, w, wd, sp, a, dt);
    settle();
    chk({31'h0, BREAK_IRQ}, {31'h0, x});
    if (x) begin
      rdc(ADR_STAT, 32'hff);
      wr(ADR_STAT, 32'h40);
    end
  endtask
  task automatic dcase(input logic [1:0] dm, input logic wd, input logic [1:0] sp,
                       input logic odd, input logic [15:0] dt, input logic x);
    wr(ADR_CTRL, {24'h0, 1'b1, CSEL_RW, ACMP_12, dm});
    bus(1'b0, 1'b0, wd, sp, 16'h1230 | {15'h0, odd}, dt, x);
  endtask
  // ==========================================================
  // main sequence
  initial begin
    {PSEL, PENABLE, PWRITE, PADDR, PWDATA} = '0;
    exc_seen = 1'b0;
    RST_N = 1'b0;
    repeat (16) @(posedge MCLK);
    RST_N <= 1'b1;
    rdc(ADR_CTRL, 32'h80);
    rdc(ADR_STAT, 32'h3f);
    rdc(ADR_BADDR, 32'hffff);
    apb(1'b0, 8'h20, 32'h0, d, e);
    chk({31'h0, e}, 32'h1);
    wr(ADR_BADDR, 32'h1234);
    rdc(ADR_BADDR, 32'h1234);
    wr(ADR_BDATA, 32'ha55a);
    rdc(ADR_BDATA, 32'ha55a);
    wr(ADR_STAT, 32'h40);
    rdc(ADR_STAT, 32'h7f);
    for (int c = 0; c < 4; c++) begin
      cs = c[1:0];
      wr(ADR_CTRL, {24'h0, 1'b1, cs, ACMP_16, DCMP_NONE});
      bus(1'b1, 1'b0, 1'b0, SPACE_RAM, 16'h1234, 16'h0, cs == CSEL_FETCH);
      bus(1'b0, 1'b0, 1'b0, SPACE_RAM, 16'h1234, 16'h0, cs[0]);
      bus(1'b0, 1'b1, 1'b0, SPACE_RAM, 16'h1234, 16'h0, cs[1]);
    end
    for (int k = 0; k < 4; k++) begin
      am = 16'h1 << (4 * k);
      wr(ADR_CTRL, {24'h0, 1'b1, CSEL_FETCH, k[2:0], DCMP_NONE});
      bus(1'b1, 1'b0, 1'b0, SPACE_ROM, 16'h1234 ^ am, 16'h0, 1'b0);
      bus(1'b1, 1'b0, 1'b0, SPACE_ROM, 16'h1234 ^ (am - 16'h1), 16'h0, 1'b1);
    end
    wr(ADR_BADDR, 32'h1230);
    dcase(DCMP_HIGH, 1'b0, SPACE_RAM, 1'b1, 16'ha500, 1'b1);
    dcase(DCMP_LOW, 1'b0, SPACE_RAM, 1'b0, 16'h005a, 1'b0);
    dcase(DCMP_LOW, 1'b1, SPACE_ROM, 1'b1, 16'h005a, 1'b1);
    dcase(DCMP_HIGH, 1'b1, SPACE_ROM, 1'b1, 16'ha5a5, 1'b0);
    dcase(DCMP_HIGH, 1'b1, SPACE_IO16, 1'b1, 16'ha5a5, 1'b0);
    dcase(DCMP_HIGH, 1'b1, SPACE_IO8, 1'b1, 16'ha500, 1'b1);
    dcase(DCMP_ALL, 1'b1, SPACE_RAM, 1'b0, 16'ha55a, 1'b1);
    dcase(DCMP_ALL, 1'b1, SPACE_RAM, 1'b0, 16'ha55b, 1'b0);
    dcase(DCMP_HIGH, 1'b1, SPACE_IO8, 1'b0, 16'h33a5, 1'b1);
    // second half of a split read must keep the read type after the bus moves on
    wr(ADR_CTRL, {24'h0, 1'b1, CSEL_READ, ACMP_12, DCMP_HIGH});
    bus(1'b0, 1'b0, 1'b1, SPACE_IO8, 16'h1230, 16'h33a5, 1'b1);
    // enable off: flag still sets, request stays low
    wr(ADR_STAT, 32'h0);
    dcase(DCMP_NONE, 1'b1, SPACE_RAM, 1'b0, 16'h0, 1'b0);
    wr(ADR_STAT, 32'h0);
    rdc(ADR_STAT, 32'hbf);
    wr(ADR_STAT, 32'hc0);
    settle();
    chk({31'h0, BREAK_IRQ}, 32'h1);
    exc_seen = 1'b0;
    cpu.seq(1'b0, 1'b1, 1'b0);
    cpu.seq(1'b1, 1'b0, 1'b0);
    settle();
    chk({31'h0, exc_seen}, 32'h0);
    cpu.seq(1'b0, 1'b1, 1'b0);
    settle();
    chk({31'h0, exc_seen}, 32'h1);
    rdc(ADR_STAT, 32'hff);
    wr(ADR_STAT, 32'h40);
    settle();
    chk({31'h0, BREAK_IRQ}, 32'h0);
    chk({31'h0, EVT_IRQ}, 32'h0);
    wr(ADR_EMASK, 32'h3);
    settle();
    chk({31'h0, EVT_IRQ}, 32'h1);
    rdc(ADR_EVT, 32'h3);
    wr(ADR_EVT, 32'h3);
    rdc(ADR_EVT, 32'h0);
    chk({31'h0, EVT_IRQ}, 32'h0);
    cpu.seq(1'b0, 1'b0, 1'b1);
    settle();
    chk({31'h0, IRQ_BLOCK}, 32'h0);
    wr(ADR_CTRL, 32'h0);
    cpu.seq(1'b0, 1'b0, 1'b1);
    settle();
    chk({31'h0, IRQ_BLOCK}, 32'h1);
    cpu.seq(1'b0, 1'b1, 1'b0);
    settle();
    chk({31'h0, IRQ_BLOCK}, 32'h0);
    conclude();
  end
endmodule
